// *** logic/sep_pkg.sv ***
// Purpose: Shared constants for the serial EEPROM command and protection block
// Assumes: 10 MHz system clock, serial link sampled as ordinary inputs
// Notes:   Opcode patterns compare with bit 3 masked off
package sep_pkg;

  // ------------------------------------------------------------
  // Opcodes (bit 3 is a don't care or the ninth address bit)
  // ------------------------------------------------------------
  localparam logic [7:0] SEP_OP_MASK          = 8'hF7;
  localparam logic [7:0] SEP_SET_WRITE_LATCH  = 8'h06;
  localparam logic [7:0] SEP_CLR_WRITE_LATCH  = 8'h04;
  localparam logic [7:0] SEP_READ_STATUS      = 8'h05;
  localparam logic [7:0] SEP_WRITE_STATUS     = 8'h01;
  localparam logic [7:0] SEP_READ_ARRAY       = 8'h03;
  localparam logic [7:0] SEP_WRITE_ARRAY      = 8'h02;
  localparam int         SEP_ADDR_HI_BIT      = 3;

  // ------------------------------------------------------------
  // Status layout and reset values
  // ------------------------------------------------------------
  localparam int         SEP_ST_BUSY          = 0;
  localparam int         SEP_ST_LATCH         = 1;
  localparam int         SEP_ST_BP_LO         = 2;
  localparam int         SEP_ST_BP_HI         = 3;
  localparam logic [1:0] SEP_BP_RESET         = 2'h0;
  localparam logic [7:0] SEP_STATUS_BUSY_ALL  = 8'hFF;

  // ------------------------------------------------------------
  // Geometry and timing
  // ------------------------------------------------------------
  localparam int         SEP_PAGE_BYTES       = 16;
  localparam int         SEP_CLK_HZ           = 10_000_000;
  localparam int         SEP_WRITE_TIME_MS    = 5;
  localparam int         SEP_WRITE_CYCLES     = SEP_WRITE_TIME_MS * (SEP_CLK_HZ / 1000);

  typedef enum logic [2:0] {
    SEP_IDLE    = 3'b000,
    SEP_OPCODE  = 3'b001,
    SEP_ADDRESS = 3'b011,
    SEP_DATA    = 3'b010,
    SEP_STATUS  = 3'b110,
    SEP_IGNORE  = 3'b111
  } sep_state_t;

endpackage

// *** logic/sep_sync.sv ***
// Purpose: Two-flop synchroniser for one level
// Assumes: Input is asynchronous to clk_sys_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sep_sync (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic async_in,
  input  wire logic reset_val_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      meta_q   <= reset_val_in;
      sync_out <= reset_val_in;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** logic/sep_fifo.sv ***
// Purpose: Small synchronous FIFO for page write data
// Assumes: Single clock, power-of-two depth
// Notes:   Honest full/empty; drain side may stall
`timescale 1ns/100ps
`default_nettype none
module sep_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sep_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_q != rd_q;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || flush_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// *** logic/sep_eeprom.sv ***
// Purpose: Serial EEPROM slave: commands, status, array read and page write
// Assumes: Link pins are sampled by clk_sys_in; serial clock well below 5 MHz
// Notes:   Array contents live in flip-flops and survive only while powered
`timescale 1ns/100ps
`default_nettype none
module sep_eeprom
  import sep_pkg::*;
#(
  parameter int ADDR_BITS    = 9,
  parameter int WRITE_CYCLES = SEP_WRITE_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic chip_sel_n_in,
  input  wire logic ser_clk_in,
  input  wire logic ser_data_in,
  input  wire logic write_protect_n_in,
  output logic      ser_data_out,
  output logic      ser_data_oe_out,
  output logic      busy_out,
  output logic      write_latch_out,
  output logic [1:0] block_protect_out
);
  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int CW    = $clog2(WRITE_CYCLES + 1);

  initial begin
    if (ADDR_BITS != 8 && ADDR_BITS != 9) $error("sep_eeprom: ADDR_BITS must be 8 or 9");
    if (WRITE_CYCLES < 1) $error("sep_eeprom: WRITE_CYCLES must be positive");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic sck_d1_q;
  logic cs_d1_q;

  sep_sync u_sync_cs (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .async_in(chip_sel_n_in), .reset_val_in(1'b1), .sync_out(cs_n_s));
  sep_sync u_sync_sck (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .async_in(ser_clk_in), .reset_val_in(1'b1), .sync_out(sck_s));
  sep_sync u_sync_si (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .async_in(ser_data_in), .reset_val_in(1'b1), .sync_out(si_s));
  sep_sync u_sync_wp (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .async_in(write_protect_n_in), .reset_val_in(1'b1), .sync_out(wp_n_s));

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sck_d1_q <= 1'b1;
      cs_d1_q  <= 1'b1;
    end else begin
      sck_d1_q <= sck_s;
      cs_d1_q  <= cs_n_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  assign sck_rise = !cs_n_s && sck_s && !sck_d1_q;
  assign sck_fall = !cs_n_s && !sck_s && sck_d1_q;
  assign cs_rise  = cs_n_s && !cs_d1_q;
  assign cs_fall  = !cs_n_s && cs_d1_q;

  // ------------------------------------------------------------
  // Command state
  // ------------------------------------------------------------
  sep_state_t         state_q;
  logic [2:0]         bit_q;
  logic [7:0]         shin_q;
  logic [7:0]         shout_q;
  logic [7:0]         op_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic               byte_done_q;
  logic               is_read_q;
  logic               clr_ok_q;
  logic [7:0]         write_status_cmd_val_q;
  logic               write_status_cmd_pend_q;
  logic               arr_pend_q;
  logic               byte_end;
  logic [7:0]         byte_val;
  logic [7:0]         op_m;
  logic               latch_q;
  logic [1:0]         bp_q;
  logic               busy_q;
  logic [CW-1:0]      wcnt_q;
  logic [7:0]         mem_q [DEPTH];
  logic [7:0]         status_now;
  logic [ADDR_BITS-1:0] rd_ptr;

  assign byte_end = sck_rise && (bit_q == 3'h7);
  assign byte_val = {shin_q[6:0], si_s};
  assign op_m     = byte_val & SEP_OP_MASK;

  assign status_now = busy_q ? SEP_STATUS_BUSY_ALL
                             : {4'h0, bp_q, latch_q, 1'b0};

  // Address given with the opcode's bit 3 as bit 8 on the large variant
  function automatic logic [ADDR_BITS-1:0] full_addr(input logic [7:0] op, input logic [7:0] lo);
    logic [8:0] a;
    a = {op[SEP_ADDR_HI_BIT], lo};
    return a[ADDR_BITS-1:0];
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= SEP_IDLE;
      bit_q   <= 3'h0;
      shin_q  <= 8'h00;
      op_q    <= 8'h00;
    end else if (cs_n_s) begin
      state_q <= SEP_IDLE;
      bit_q   <= 3'h0;
    end else begin
      if (cs_fall) state_q <= SEP_OPCODE;
      if (sck_rise) begin
        bit_q  <= bit_q + 3'h1;
        shin_q <= byte_val;
      end
      if (byte_end) begin
        case (state_q)
          SEP_OPCODE: begin
            op_q <= byte_val;
            if (op_m == SEP_READ_STATUS) state_q <= SEP_STATUS;
            else if (busy_q) state_q <= SEP_IGNORE;
            else if (op_m == SEP_READ_ARRAY || op_m == SEP_WRITE_ARRAY)
              state_q <= SEP_ADDRESS;
            else if (op_m == SEP_WRITE_STATUS) state_q <= SEP_DATA;
            else state_q <= SEP_IGNORE;
          end
          SEP_ADDRESS: state_q <= SEP_DATA;
          SEP_DATA:    state_q <= SEP_DATA;
          SEP_STATUS:  state_q <= SEP_STATUS;
          SEP_IGNORE:  state_q <= SEP_IGNORE;
          default:     state_q <= SEP_IGNORE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Address pointer, read streaming and write capture
  // ------------------------------------------------------------
  logic             fifo_in_valid;
  logic [11:0]      fifo_in_data;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [11:0]      fifo_out_data;
  logic             fifo_flush;
  logic [15:0]      page_fill_q;
  logic [7:0]       page_buf_q [SEP_PAGE_BYTES];
  logic [3:0]       wr_off_q;

  assign rd_ptr = addr_q;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      addr_q      <= '0;
      is_read_q   <= 1'b0;
      byte_done_q <= 1'b0;
      write_status_cmd_val_q  <= 8'h00;
      clr_ok_q    <= 1'b0;
    end else begin
      if (cs_fall) byte_done_q <= 1'b0;
      if (byte_end && state_q == SEP_OPCODE) begin
        is_read_q   <= (op_m == SEP_READ_ARRAY);
        byte_done_q <= 1'b0;
        clr_ok_q    <= !busy_q && op_m == SEP_CLR_WRITE_LATCH;
      end
      if (byte_end && state_q == SEP_ADDRESS) begin
        addr_q <= full_addr(op_q, byte_val);
      end
      if (byte_end && state_q == SEP_DATA) begin
        byte_done_q <= 1'b1;
        if (!is_read_q && (op_q & SEP_OP_MASK) == SEP_WRITE_STATUS) write_status_cmd_val_q <= byte_val;
        if (!is_read_q && (op_q & SEP_OP_MASK) == SEP_WRITE_ARRAY)
          addr_q[3:0] <= addr_q[3:0] + 4'h1;
      end
      // Step at the end of each read byte so the next load sees the new address
      if (byte_end && state_q == SEP_DATA && is_read_q)
        addr_q <= addr_q + 1'b1;
    end
  end

  // Output shifting on falling serial clock edges
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      shout_q         <= 8'h00;
      ser_data_out    <= 1'b0;
      ser_data_oe_out <= 1'b0;
    end else if (cs_n_s) begin
      ser_data_oe_out <= 1'b0;
    end else if (sck_fall) begin
      if (bit_q == 3'h0 && state_q == SEP_STATUS) begin
        shout_q         <= {status_now[6:0], 1'b0};
        ser_data_out    <= status_now[7];
        ser_data_oe_out <= 1'b1;
      end else if (bit_q == 3'h0 && state_q == SEP_DATA && is_read_q) begin
        shout_q         <= {mem_q[rd_ptr][6:0], 1'b0};
        ser_data_out    <= mem_q[rd_ptr][7];
        ser_data_oe_out <= 1'b1;
      end else if (ser_data_oe_out) begin
        shout_q      <= {shout_q[6:0], 1'b0};
        ser_data_out <= shout_q[7];
      end
    end
  end

  // Data bytes pass through the FIFO; the page buffer drains it, and
  // capture ignores fifo_in_ready, so a stalled drain makes a full FIFO drop bytes
  assign fifo_in_valid = byte_end && state_q == SEP_DATA && !is_read_q
                         && (op_q & SEP_OP_MASK) == SEP_WRITE_ARRAY;
  assign fifo_in_data  = {addr_q[3:0], byte_val};
  assign fifo_flush    = cs_fall;

  sep_fifo #(.WIDTH(12), .DEPTH(8)) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (fifo_in_valid),
    .in_data_in    (fifo_in_data),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (!busy_q)
  );

  always_ff @(posedge clk_sys_in) begin
    // A status poll during the write cycle must not drop the captured page
    if (!resetn_in || (cs_fall && !busy_q)) begin
      page_fill_q <= 16'h0000;
    end else if (fifo_out_valid && !busy_q) begin
      page_buf_q[fifo_out_data[11:8]] <= fifo_out_data[7:0];
      page_fill_q[fifo_out_data[11:8]] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Latch, protect bits and self-timed write cycle
  // ------------------------------------------------------------
  logic cmd_complete;
  logic start_write_status_cmd;
  logic start_arr;
  logic bp_hit;
  logic [1:0] addr_top;

  assign cmd_complete = cs_rise && bit_q == 3'h0 && byte_done_q && !busy_q;
  assign start_write_status_cmd = cmd_complete && (op_q & SEP_OP_MASK) == SEP_WRITE_STATUS
                      && latch_q && wp_n_s;
  assign start_arr  = cmd_complete && (op_q & SEP_OP_MASK) == SEP_WRITE_ARRAY
                      && latch_q && wp_n_s && !fifo_out_valid;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      latch_q <= 1'b0;
    end else if (!wp_n_s) begin
      latch_q <= 1'b0;
    end else if (start_write_status_cmd || start_arr) begin
      latch_q <= 1'b0;
    end else if (cs_rise && bit_q == 3'h0 && state_q == SEP_IGNORE && clr_ok_q) begin
      latch_q <= 1'b0;
    end else if (byte_end && state_q == SEP_OPCODE && !busy_q
                 && op_m == SEP_SET_WRITE_LATCH) begin
      latch_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      busy_q      <= 1'b0;
      wcnt_q      <= '0;
      write_status_cmd_pend_q <= 1'b0;
      arr_pend_q  <= 1'b0;
      bp_q        <= SEP_BP_RESET;
    end else if (start_write_status_cmd || start_arr) begin
      busy_q      <= 1'b1;
      wcnt_q      <= CW'(WRITE_CYCLES - 1);
      write_status_cmd_pend_q <= start_write_status_cmd;
      arr_pend_q  <= start_arr;
    end else if (busy_q) begin
      if (wcnt_q == '0) begin
        busy_q      <= 1'b0;
        write_status_cmd_pend_q <= 1'b0;
        arr_pend_q  <= 1'b0;
        if (write_status_cmd_pend_q)
          bp_q <= {write_status_cmd_val_q[SEP_ST_BP_HI], write_status_cmd_val_q[SEP_ST_BP_LO]};
      end else begin
        wcnt_q <= wcnt_q - 1'b1;
      end
    end
  end

  // Protected region is the top quarter, half or all of the array
  function automatic logic in_block(input logic [ADDR_BITS-1:0] a, input logic [1:0] bp);
    logic [1:0] top;
    top = a[ADDR_BITS-1 -: 2];
    case (bp)
      2'h1:    return top == 2'h3;
      2'h2:    return top[1];
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign addr_top = addr_q[ADDR_BITS-1 -: 2];
  assign bp_hit   = 1'b0;

  // Commit the page when the write cycle finishes
  always_ff @(posedge clk_sys_in) begin
    if (busy_q && arr_pend_q && wcnt_q == '0) begin
      for (int i = 0; i < SEP_PAGE_BYTES; i++) begin
        if (page_fill_q[i] && !in_block({addr_q[ADDR_BITS-1:4], 4'(i)}, bp_q))
          mem_q[{addr_q[ADDR_BITS-1:4], 4'(i)}] <= page_buf_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      busy_out          <= 1'b0;
      write_latch_out   <= 1'b0;
      block_protect_out <= SEP_BP_RESET;
    end else begin
      busy_out          <= busy_q;
      write_latch_out   <= latch_q;
      block_protect_out <= bp_q;
    end
  end

  logic unused_ok;
  assign unused_ok = fifo_in_ready ^ bp_hit ^ ^addr_top;
endmodule
`default_nettype wire

// *** sim/sep_eeprom_assertions.sv ***
// Purpose: Port-level checks for the serial EEPROM block
// Assumes: Pins pass two sync flops, so windows allow a few cycles of lag
// Notes:   Bound to every sep_eeprom instance
`timescale 1ns/100ps
`default_nettype none
module sep_eeprom_assertions #(
  parameter int ADDR_BITS    = 9,
  parameter int WRITE_CYCLES = 200
) (
  input wire logic       clk_sys_in,
  input wire logic       resetn_in,
  input wire logic       chip_sel_n_in,
  input wire logic       ser_clk_in,
  input wire logic       ser_data_in,
  input wire logic       write_protect_n_in,
  input wire logic       ser_data_out,
  input wire logic       ser_data_oe_out,
  input wire logic       busy_out,
  input wire logic       write_latch_out,
  input wire logic [1:0] block_protect_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  logic [31:0] busy_cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || !busy_out) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_cs_idle;
    chip_sel_n_in [*6];
  endsequence
  sequence s_write_start;
    $rose(busy_out);
  endsequence

  a_reset_clears_state: assert property (disable iff (1'b0) !resetn_in |=>
    !busy_out && !write_latch_out && block_protect_out == 2'h0) else $error("reset state");
  a_protect_drops_latch: assert property (!write_protect_n_in [*4] |=>
    !write_latch_out) else $error("latch set under protect pin");
  a_idle_no_drive: assert property (s_cs_idle |-> !ser_data_oe_out)
    else $error("output driven while deselected");
  a_latch_set_idle: assert property ($rose(write_latch_out) |->
    !$past(busy_out) && !chip_sel_n_in) else $error("latch set while busy");
  a_write_after_cs: assert property (s_write_start |-> chip_sel_n_in ##[0:3]
    !write_latch_out) else $error("write start without latch clear");
  a_wp_blocks_write: assert property (s_write_start |->
    $past(write_protect_n_in, 6)) else $error("write under protect pin");
  a_busy_span_len: assert property ($fell(busy_out) |->
    busy_cnt_q inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]}) else $error("write cycle length");
  a_bp_hold_busy: assert property (busy_out && $past(busy_out) |->
    $stable(block_protect_out)) else $error("protect bits moved mid cycle");
  a_bp_write_end: assert property ($changed(block_protect_out) |->
    $past(busy_out) || $past(busy_out, 2)) else $error("protect bits moved outside write");
  a_busy_reads_ones: assert property (busy_out && $past(busy_out, 4) &&
    ser_data_oe_out |-> ser_data_out) else $error("busy status not ones");
  a_oe_in_frame: assert property ($rose(ser_data_oe_out) |-> !chip_sel_n_in)
    else $error("output enabled outside frame");
endmodule
bind sep_eeprom sep_eeprom_assertions #(.ADDR_BITS(ADDR_BITS), .WRITE_CYCLES(WRITE_CYCLES))
  u_chk (.clk_sys_in, .resetn_in, .chip_sel_n_in, .ser_clk_in, .ser_data_in,
  .write_protect_n_in, .ser_data_out, .ser_data_oe_out, .busy_out, .write_latch_out,
  .block_protect_out);
`default_nettype wire

// *** sim/sep_master.sv ***
// Purpose: Behavioural SPI master in mode 0 facing the EEPROM block
// Assumes: half counts system cycles per serial half period
// Notes:   half can be raised to act as a slow master
`timescale 1ns/100ps
`default_nettype none
module sep_master (
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  int   half   = 4;
  logic last_q = 1'b0;
  logic miso;
  always @(posedge clk_in) if (miso_oe_in) last_q <= miso_in;
  // Released line shows the inverse of its last bit, never a stale copy
  assign miso = miso_oe_in ? miso_in : ~last_q;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    cs_n_out = 1'b0;
    tick(half);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      tick(half);
      rx[i] = miso;
      sclk_out = 1'b1;
      tick(half);
      sclk_out = 1'b0;
    end
  endtask
  task automatic stop();
    tick(half);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    tick(2 * half);
  endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the serial EEPROM block
// Assumes: Short write cycle; array content tracked only where written
// Notes:   Status compare masks the latch bit, checked on its own
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sep_pkg::*;
;
  localparam int WC = 200;
  logic       clk_sys_in;
  logic       resetn_in;
  logic       wp_n;
  wire logic  cs_n, sclk, mosi, miso, miso_oe, busy, latch;
  wire logic [1:0] bp;
  logic [7:0] mem [512];
  logic [7:0] rx;
  logic [1:0] exp_bp = 2'h0;
  int         errors;
  int         cmp_count;

  sep_eeprom #(.ADDR_BITS(9), .WRITE_CYCLES(WC)) u_sep_eeprom (.clk_sys_in, .resetn_in,
    .chip_sel_n_in(cs_n), .ser_clk_in(sclk), .ser_data_in(mosi),
    .write_protect_n_in(wp_n), .ser_data_out(miso), .ser_data_oe_out(miso_oe),
    .busy_out(busy), .write_latch_out(latch), .block_protect_out(bp));
  sep_master u_sep_master (.clk_in(clk_sys_in), .miso_in(miso), .miso_oe_in(miso_oe),
    .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    u_sep_master.start();
    u_sep_master.xfer(op, rx);
    u_sep_master.stop();
  endtask
  task automatic poll();
    u_sep_master.start();
    u_sep_master.xfer(SEP_READ_STATUS, rx);
    for (int i = 0; i < 40; i++) begin
      u_sep_master.xfer(8'h00, rx);
      if (rx[0] !== 1'b1) break;
      check("busy status", 8'hFF, rx);
    end
    u_sep_master.stop();
    check("status", {4'h0, exp_bp, 2'h0}, rx & 8'hFD);
  endtask
  task automatic ws(input logic [7:0] v, input bit ok);
    u_sep_master.start();
    u_sep_master.xfer(SEP_WRITE_STATUS, rx);
    u_sep_master.xfer(v, rx);
    u_sep_master.stop();
    if (ok) exp_bp = v[3:2];
  endtask
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] v, input bit ok);
    u_sep_master.start();
    u_sep_master.xfer(SEP_WRITE_ARRAY | {4'h0, a[8], 3'h0}, rx);
    u_sep_master.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_sep_master.xfer(v + 8'(i), rx);
      if (ok) mem[{a[8:4], 4'(a[3:0] + i)}] = v + 8'(i);
    end
    u_sep_master.stop();
    poll();
  endtask
  task automatic rd(input logic [8:0] a, input int n);
    u_sep_master.start();
    u_sep_master.xfer(SEP_READ_ARRAY | {4'h0, a[8], 3'h0}, rx);
    u_sep_master.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_sep_master.xfer(8'h00, rx);
      check("array byte", mem[9'(a + i)], rx);
    end
    u_sep_master.stop();
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    wp_n = 1'b1;
    errors = 0;
    cmp_count = 0;
    // Two cycles of reset; every register except the array, page buffer and FIFO storage takes its reset value on the first edge
    repeat (2) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    u_sep_master.tick(4);
    check("reset flags", 8'h00, {4'h0, bp, latch, busy});
    cmd(SEP_SET_WRITE_LATCH);
    check("latch set", 8'h01, {7'h0, latch});
    cmd(SEP_CLR_WRITE_LATCH);
    check("latch clear", 8'h00, {7'h0, latch});
    cmd(SEP_SET_WRITE_LATCH | 8'h08);
    check("latch set x", 8'h01, {7'h0, latch});
    $display("test latch commands done");
    wr(9'h11C, 20, 8'h40, 1'b1);
    check("latch after write", 8'h00, {7'h0, latch});
    rd(9'h110, 16);
    $display("test page write done");
    cmd(SEP_SET_WRITE_LATCH);
    wr(9'h1F8, 8, 8'h80, 1'b1);
    cmd(SEP_SET_WRITE_LATCH);
    wr(9'h000, 4, 8'hA0, 1'b1);
    u_sep_master.half = 6;
    rd(9'h1FC, 8);
    u_sep_master.half = 4;
    $display("test read wrap done");
    wr(9'h000, 2, 8'h55, 1'b0);
    cmd(SEP_SET_WRITE_LATCH);
    wp_n = 1'b0;
    u_sep_master.tick(8);
    check("latch under protect", 8'h00, {7'h0, latch});
    wr(9'h000, 2, 8'h66, 1'b0);
    wp_n = 1'b1;
    rd(9'h000, 4);
    $display("test refused writes done");
    cmd(SEP_SET_WRITE_LATCH);
    ws(8'hF4, 1'b1);
    poll();
    ws(8'h0C, 1'b0);
    poll();
    cmd(SEP_SET_WRITE_LATCH);
    wr(9'h1FE, 2, 8'h11, 1'b0);
    cmd(SEP_SET_WRITE_LATCH);
    wr(9'h000, 2, 8'h22, 1'b1);
    rd(9'h1FE, 4);
    cmd(SEP_SET_WRITE_LATCH);
    ws(8'h00, 1'b1);
    cmd(SEP_SET_WRITE_LATCH);
    poll();
    check("latch set while busy", 8'h00, {7'h0, latch});
    $display("test block protect done");
    results();
  end
endmodule
`default_nettype wire
